// ### design/rft_timer_control.sv
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module rft_timer_control #(
  parameter int unsigned ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Tick strobes and cascade inputs, same clock
  input  wire logic              tick_13m56_i,
  input  wire logic              tick_211k_i,
  input  wire logic              timer1_underflow_i,
  input  wire logic              timer2_underflow_i,
  // RF frame events, same clock
  input  wire logic              tx_end_i,
  input  wire logic              rx_first4_i,
  // Low-frequency oscillator, asynchronous
  input  wire logic              low_freq_oscillator_i,
  // Status
  output logic                   timer0_underflow_o,
  output logic                   timer_underflow_irq_flag_o,
  output logic [3:0]             timer_active_o
);

  typedef struct packed {
    logic                aw_held;
    logic [7:0]          aw_idx;
    logic                w_held;
    logic [7:0]          w_data;
    logic                w_lane0;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [7:0]          rdata;
    logic [1:0]          rresp;
    logic [3:1]          flags;
    rft_pkg::rft_tstate_t t0;
    logic [7:0]          ctl;
    logic [7:0]          rl_hi;
    logic [7:0]          rl_lo;
    logic [15:0]         count;
    logic                irq;
    logic                uf;
    logic [2:0]          lfo_sync;
  } rft_state_t;

  rft_state_t s;
  rft_state_t next_s;

  logic       wr_go;
  logic       wr_en;
  logic       tsc_wr;
  logic       t0_running;
  logic       tick;
  logic       lfo_edge;
  logic       lfo_mode;
  logic       start_ev;
  logic       stop_ev;
  logic       uf_now;
  logic [7:0] rd_idx;

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    return a[rft_pkg::ADDR_LSB +: 8];
  endfunction

  function automatic logic is_mapped(input logic [7:0] idx);
    return (idx >= rft_pkg::IDX_TSC && idx <= rft_pkg::IDX_CNT_LO) ||
           (idx == rft_pkg::IDX_IRQ);
  endfunction

  assign s_axi_awready_o            = !s.aw_held;
  assign s_axi_wready_o             = !s.w_held;
  assign s_axi_bvalid_o             = s.bvalid;
  assign s_axi_bresp_o              = s.bresp;
  assign s_axi_arready_o            = !s.rvalid;
  assign s_axi_rvalid_o             = s.rvalid;
  assign s_axi_rresp_o              = s.rresp;
  assign s_axi_rdata_o              = {24'h00_0000, s.rdata};
  assign timer0_underflow_o         = s.uf;
  assign timer_underflow_irq_flag_o = s.irq;
  assign timer_active_o             = {s.flags, t0_running};

  always_comb
  begin
    next_s     = s;
    wr_go      = s.aw_held && s.w_held && !s.bvalid;
    // A write with lane 0 off is acknowledged but stores nothing
    wr_en      = wr_go && s.w_lane0;
    tsc_wr     = wr_en && s.aw_idx == rft_pkg::IDX_TSC;
    t0_running = s.t0 == rft_pkg::RFT_RUN;
    rd_idx     = reg_index(s_axi_araddr_i);
    lfo_edge   = s.lfo_sync[1] && !s.lfo_sync[2];
    lfo_mode   = s.ctl[rft_pkg::CTL_MODE_LO + 1];
    uf_now     = 1'b0;
    case (s.ctl[rft_pkg::CTL_SEL_LO +: 2])
      rft_pkg::SEL_13M56: tick = tick_13m56_i;
      rft_pkg::SEL_211K:  tick = tick_211k_i;
      rft_pkg::SEL_T2_UF: tick = timer2_underflow_i;
      default:            tick = timer1_underflow_i;
    endcase

    // Write address and data are taken independently
    if (s_axi_awvalid_i && !s.aw_held)
    begin
      next_s.aw_held = 1'b1;
      next_s.aw_idx  = reg_index(s_axi_awaddr_i);
    end
    if (s_axi_wvalid_i && !s.w_held)
    begin
      next_s.w_held  = 1'b1;
      next_s.w_data  = s_axi_wdata_i[7:0];
      next_s.w_lane0 = s_axi_wstrb_i[0];
    end
    if (s.bvalid && s_axi_bready_i)
    begin
      next_s.bvalid = 1'b0;
    end
    if (wr_go)
    begin
      next_s.aw_held = 1'b0;
      next_s.w_held  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = is_mapped(s.aw_idx) ? rft_pkg::RESP_OKAY : rft_pkg::RESP_SLVERR;
    end

    // Timers 1..3 exist elsewhere; only their flags live here
    for (int i = 1; i < 4; i++)
    begin
      if (tsc_wr && s.w_data[i])
      begin
        next_s.flags[i] = s.w_data[rft_pkg::TSC_FLAG_LO + i];
      end
    end
    if (wr_en)
    begin
      case (s.aw_idx)
        rft_pkg::IDX_T0_CTL: next_s.ctl   = s.w_data & rft_pkg::CTL_RW_MASK;
        rft_pkg::IDX_RL_HI:  next_s.rl_hi = s.w_data;
        rft_pkg::IDX_RL_LO:  next_s.rl_lo = s.w_data;
        default:             next_s.ctl   = s.ctl;
      endcase
    end

    // Start outranks stop in the same cycle, whether either comes from software or hardware
    start_ev = (tsc_wr && s.w_data[0] && s.w_data[rft_pkg::TSC_FLAG_LO]) ||
      (!t0_running && s.ctl[rft_pkg::CTL_MODE_LO +: 2] == rft_pkg::MODE_TXEND &&
       tx_end_i) ||
      (!t0_running && lfo_mode && lfo_edge);
    stop_ev = (tsc_wr && s.w_data[0] && !s.w_data[rft_pkg::TSC_FLAG_LO]) ||
      (t0_running && s.ctl[rft_pkg::CTL_HALT] && !lfo_mode && rx_first4_i) ||
      (t0_running && lfo_mode && lfo_edge);

    case (s.t0)
      rft_pkg::RFT_IDLE:
      begin
        if (start_ev)
        begin
          next_s.t0    = rft_pkg::RFT_RUN;
          next_s.count = {s.rl_hi, s.rl_lo};
        end
      end
      rft_pkg::RFT_RUN:
      begin
        if (start_ev)
        begin
          next_s.count = {s.rl_hi, s.rl_lo};
        end
        else if (stop_ev)
        begin
          next_s.t0 = rft_pkg::RFT_IDLE;
        end
        else if (tick && s.count <= 16'h0001)
        begin
          next_s.count = rft_pkg::RST_COUNT;
          // Trimming without underflow parks at zero until the next edge
          if (s.ctl[rft_pkg::CTL_MODE_LO +: 2] != rft_pkg::MODE_LFO)
          begin
            uf_now = 1'b1;
            if (s.ctl[rft_pkg::CTL_AUTO])
            begin
              next_s.count = {s.rl_hi, s.rl_lo};
            end
            else
            begin
              next_s.t0 = rft_pkg::RFT_IDLE;
            end
          end
        end
        else if (tick)
        begin
          next_s.count = s.count - 16'h0001;
        end
      end
      default: next_s.t0 = rft_pkg::RFT_IDLE;
    endcase
    next_s.uf = uf_now;
    // Underflow in the clearing cycle keeps the flag set
    next_s.irq = (s.irq && !(wr_en && s.aw_idx == rft_pkg::IDX_IRQ && s.w_data[0])) ||
                 uf_now;

    if (s.rvalid && s_axi_rready_i)
    begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && !s.rvalid)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = is_mapped(rd_idx) ? rft_pkg::RESP_OKAY : rft_pkg::RESP_SLVERR;
      case (rd_idx)
        rft_pkg::IDX_TSC:    next_s.rdata = {s.flags, t0_running, 4'h0};
        rft_pkg::IDX_T0_CTL: next_s.rdata = s.ctl;
        rft_pkg::IDX_RL_HI:  next_s.rdata = s.rl_hi;
        rft_pkg::IDX_RL_LO:  next_s.rdata = s.rl_lo;
        rft_pkg::IDX_CNT_HI: next_s.rdata = s.count[15:8];
        rft_pkg::IDX_CNT_LO: next_s.rdata = s.count[7:0];
        rft_pkg::IDX_IRQ:    next_s.rdata = {7'h00, s.irq};
        default:             next_s.rdata = rft_pkg::RST_BYTE;
      endcase
    end

    next_s.lfo_sync = {s.lfo_sync[1:0], low_freq_oscillator_i};
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s          <= '0;
      s.t0       <= rft_pkg::RFT_IDLE;
      s.ctl      <= rft_pkg::RST_BYTE;
      s.count    <= rft_pkg::RST_COUNT;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Hardware start, stop or underflow may still move timer 0 in that cycle
  property p_mask_hold;
    tsc_wr && s.w_data[3:0] == 4'h0
      |=> s.flags == $past(s.flags) && (t0_running == $past(t0_running) ||
          $past(start_ev) || $past(stop_ev) || $past(uf_now));
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("Unmasked flag changed");

  property p_all_set;
    tsc_wr && s.w_data == 8'hff |=> timer_active_o == 4'hf;
  endproperty
  a_all_set: assert property (p_all_set) else $error("FFh did not start all");

  property p_tsc_read;
    s_axi_arvalid_i && s_axi_arready_o && rd_idx == rft_pkg::IDX_TSC
      |=> s_axi_rdata_o[3:0] == 4'h0 && s_axi_rdata_o[7:4] == $past(timer_active_o);
  endproperty
  a_tsc_read: assert property (p_tsc_read) else $error("Control read wrong");

  property p_rx_stop;
    t0_running && s.ctl[rft_pkg::CTL_HALT] && !lfo_mode && rx_first4_i && !tsc_wr
      |=> !t0_running;
  endproperty
  a_rx_stop: assert property (p_rx_stop) else $error("No stop on receive");

  property p_lfo_no_rx;
    t0_running && lfo_mode && rx_first4_i && !lfo_edge && !tsc_wr && !uf_now
      |=> t0_running;
  endproperty
  a_lfo_no_rx: assert property (p_lfo_no_rx) else $error("Receive stopped trim");

  property p_tx_start;
    !t0_running && s.ctl[rft_pkg::CTL_MODE_LO +: 2] == rft_pkg::MODE_TXEND && tx_end_i && !tsc_wr
      |=> t0_running && s.count == {$past(s.rl_hi), $past(s.rl_lo)};
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("No start on TX end");

  sequence s_uf_auto;
    s.uf && $past(s.ctl[rft_pkg::CTL_AUTO]);
  endsequence
  // Settings as they stood at the underflow edge, not any write landing there
  property p_reload;
    s_uf_auto |-> t0_running && s.count == {$past(s.rl_hi), $past(s.rl_lo)} && s.irq;
  endproperty
  a_reload: assert property (p_reload) else $error("Auto reload failed");

  property p_stop_zero;
    s.uf && !$past(s.ctl[rft_pkg::CTL_AUTO]) |-> !t0_running && s.count == rft_pkg::RST_COUNT;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("No stop at zero");

  property p_irq;
    s.uf |-> timer_underflow_irq_flag_o;
  endproperty
  a_irq: assert property (p_irq) else $error("Underflow lost irq flag");

  property p_reload_quiet;
    t0_running && wr_en && (s.aw_idx == rft_pkg::IDX_RL_HI || s.aw_idx == rft_pkg::IDX_RL_LO)
      && !tick && !start_ev |=> s.count == $past(s.count);
  endproperty
  a_reload_quiet: assert property (p_reload_quiet) else $error("Reload hit count");

  property p_dec;
    t0_running && tick && s.count > 16'h0001 && !start_ev && !stop_ev
      |=> s.count == $past(s.count) - 16'h0001 && !s.uf;
  endproperty
  a_dec: assert property (p_dec) else $error("Bad decrement");

endmodule
`default_nettype wire

// ### design/rft_pkg.sv
`default_nettype none
package rft_pkg;
  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_LSB    = 2;
  localparam logic [7:0]  IDX_TSC     = 8'h0e;
  localparam logic [7:0]  IDX_T0_CTL  = 8'h0f;
  localparam logic [7:0]  IDX_RL_HI   = 8'h10;
  localparam logic [7:0]  IDX_RL_LO   = 8'h11;
  localparam logic [7:0]  IDX_CNT_HI  = 8'h12;
  localparam logic [7:0]  IDX_CNT_LO  = 8'h13;
  localparam logic [7:0]  IDX_IRQ     = 8'h20;
  // Timer-section control layout
  localparam int unsigned TSC_FLAG_LO = 4;
  // Timer 0 control layout
  localparam int unsigned CTL_HALT    = 7;
  localparam int unsigned CTL_MODE_LO = 4;
  localparam int unsigned CTL_AUTO    = 3;
  localparam int unsigned CTL_SEL_LO  = 0;
  // Bits 6 and 2 are reserved; the tick select spans bits 1..0
  localparam logic [7:0]  CTL_RW_MASK = 8'hbb;
  // Trigger modes
  localparam logic [1:0]  MODE_NONE   = 2'h0;
  localparam logic [1:0]  MODE_TXEND  = 2'h1;
  localparam logic [1:0]  MODE_LFO    = 2'h2;
  localparam logic [1:0]  MODE_LFO_UF = 2'h3;
  // Tick sources
  localparam logic [1:0]  SEL_13M56   = 2'h0;
  localparam logic [1:0]  SEL_211K    = 2'h1;
  localparam logic [1:0]  SEL_T2_UF   = 2'h2;
  localparam logic [1:0]  SEL_T1_UF   = 2'h3;
  // Reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    RFT_IDLE = 2'h1,
    RFT_RUN  = 2'h2
  } rft_tstate_t;
endpackage
`default_nettype wire

// ### tb/rf_frontend_timer_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rf_frontend_timer_control_tb;
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0000_0000;
  logic [31:0] rdata;
  logic [5:0]  ev      = 6'h00;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        low_freq_oscillator     = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, uf, irq, last_uf;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  active;
  logic [31:0] got;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc       = 0;

  always #2.5 clock_i = ~clock_i;

  rft_timer_control #(.ADDR_W(12)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .tick_13m56_i(ev[0]), .tick_211k_i(ev[1]), .timer1_underflow_i(ev[2]),
    .timer2_underflow_i(ev[3]), .tx_end_i(ev[4]), .rx_first4_i(ev[5]),
    .low_freq_oscillator_i(low_freq_oscillator), .timer0_underflow_o(uf),
    .timer_underflow_irq_flag_o(irq), .timer_active_o(active)
  );

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ready is sampled at the falling edge, where it is settled, and the
  // item is taken at the following rising edge
  task automatic axi_write(input logic [11:0] a, input logic [7:0] d);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge clock_i);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(negedge clock_i);
      if (awready && !aw_done) aw_done = 1;
      if (wready && !w_done) w_done = 1;
      @(posedge clock_i);
      if (aw_done) awvalid <= 1'b0;
      if (w_done) wvalid <= 1'b0;
    end
    do @(negedge clock_i); while (!bvalid);
    resp = bresp;
    @(posedge clock_i);
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a);
    @(posedge clock_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clock_i); while (!arready);
    @(posedge clock_i);
    arvalid <= 1'b0;
    do @(negedge clock_i); while (!rvalid);
    got = rdata;
    resp = rresp;
    @(posedge clock_i);
    rready <= 1'b0;
  endtask

  task automatic rd(input string name, input logic [7:0] idx, input logic [7:0] exp);
    axi_read(ad(idx));
    chk(name, {24'h00_0000, exp}, got);
    chk("rresp", {30'h0, rft_pkg::RESP_OKAY}, {30'h0, resp});
  endtask

  // One-cycle event strobe; it acts at the edge where it is high
  task automatic pulse(input int k);
    @(posedge clock_i);
    ev[k] <= 1'b1;
    @(posedge clock_i);
    ev[k] <= 1'b0;
    @(negedge clock_i);
    last_uf = uf;
  endtask

  task automatic act(input logic [3:0] exp);
    @(negedge clock_i);
    chk("active", {28'h000_0000, exp}, {28'h000_0000, active});
  endtask

  task automatic lfo_edge();
    @(posedge clock_i);
    low_freq_oscillator <= 1'b1;
    repeat (6) @(posedge clock_i);
    low_freq_oscillator <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd("tsc reset", rft_pkg::IDX_TSC, 8'h00);
    rd("ctl reset", rft_pkg::IDX_T0_CTL, 8'h00);
    rd("cnt reset", rft_pkg::IDX_CNT_HI, 8'h00);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'hff);
    rd("ctl reserved", rft_pkg::IDX_T0_CTL, 8'hbb);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h00);
    axi_write(ad(rft_pkg::IDX_RL_HI), 8'h00);
    axi_write(ad(rft_pkg::IDX_RL_LO), 8'h02);
    rd("reload lo", rft_pkg::IDX_RL_LO, 8'h02);
    axi_write(ad(rft_pkg::IDX_TSC), 8'hff);
    act(4'hf);
    rd("tsc all", rft_pkg::IDX_TSC, 8'hf0);
    axi_write(ad(rft_pkg::IDX_TSC), 8'hf0);
    rd("tsc nomask", rft_pkg::IDX_TSC, 8'hf0);
    axi_write(ad(rft_pkg::IDX_TSC), 8'h0e);
    rd("tsc masked", rft_pkg::IDX_TSC, 8'h10);
    act(4'h1);
    axi_write(ad(rft_pkg::IDX_RL_LO), 8'h05);
    rd("cnt run", rft_pkg::IDX_CNT_LO, 8'h02);
    pulse(0);
    pulse(1);
    rd("cnt tick", rft_pkg::IDX_CNT_LO, 8'h01);
    pulse(0);
    chk("uf", 32'h1, {31'h0, last_uf});
    chk("irq", 32'h1, {31'h0, irq});
    act(4'h0);
    rd("cnt zero", rft_pkg::IDX_CNT_LO, 8'h00);
    rd("irq reg", rft_pkg::IDX_IRQ, 8'h01);
    axi_write(ad(rft_pkg::IDX_IRQ), 8'h01);
    @(negedge clock_i);
    chk("irq clr", 32'h0, {31'h0, irq});
    axi_write(ad(rft_pkg::IDX_TSC), 8'h11);
    rd("cnt load", rft_pkg::IDX_CNT_LO, 8'h05);
    axi_write(ad(rft_pkg::IDX_TSC), 8'h01);
    act(4'h0);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h09);
    axi_write(ad(rft_pkg::IDX_RL_LO), 8'h02);
    axi_write(ad(rft_pkg::IDX_TSC), 8'h11);
    pulse(0);
    pulse(1);
    pulse(1);
    chk("uf auto", 32'h1, {31'h0, last_uf});
    act(4'h1);
    rd("cnt auto", rft_pkg::IDX_CNT_LO, 8'h02);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h02);
    pulse(2);
    rd("cnt t2 sel", rft_pkg::IDX_CNT_LO, 8'h02);
    pulse(3);
    rd("cnt t2 uf", rft_pkg::IDX_CNT_LO, 8'h01);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h03);
    pulse(2);
    chk("uf t1", 32'h1, {31'h0, last_uf});
    act(4'h0);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h80);
    pulse(4);
    act(4'h0);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h90);
    pulse(4);
    act(4'h1);
    pulse(5);
    act(4'h0);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h10);
    pulse(4);
    pulse(5);
    act(4'h1);
    axi_write(ad(rft_pkg::IDX_TSC), 8'h01);
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'hb0);
    lfo_edge();
    act(4'h1);
    pulse(5);
    act(4'h1);
    lfo_edge();
    act(4'h0);
    // Trimming without underflow: parks at zero, no pulse, still running
    axi_write(ad(rft_pkg::IDX_T0_CTL), 8'h20);
    lfo_edge();
    act(4'h1);
    pulse(0);
    pulse(0);
    chk("uf trim", 32'h0, {31'h0, last_uf});
    act(4'h1);
    rd("cnt park", rft_pkg::IDX_CNT_LO, 8'h00);
    lfo_edge();
    act(4'h0);
    axi_read(12'h100);
    chk("rresp unmapped", {30'h0, rft_pkg::RESP_SLVERR}, {30'h0, resp});
    chk("rdata unmapped", 32'h0000_0000, got);
    axi_write(12'h100, 8'h55);
    chk("bresp unmapped", {30'h0, rft_pkg::RESP_SLVERR}, {30'h0, resp});
    tally_and_finish();
  end
endmodule
`default_nettype wire
